// *** design/ext_timer_pkg.sv ***
package ext_timer_pkg;

  // ==========================================================================
  // register map (byte registers on an 8-bit port)
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h3;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h4;
  localparam logic [2:0] ADDR_CMPB_LO = 3'h5;
  localparam logic [2:0] ADDR_CMPB_HI = 3'h6;

  // ==========================================================================
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_OVE_BIT = 1;
  localparam int ST_CAPA_BIT = 0;
  localparam int ST_CAPB_BIT = 1;
  localparam int ST_OVF_BIT = 2;

  // ==========================================================================
  // operating mode codes
  localparam logic [2:0] MODE_EVENT = 3'h2;
  localparam logic [2:0] MODE_EXT_TRIG = 3'h4;
  localparam logic [2:0] MODE_WINDOW = 3'h5;
  localparam logic [2:0] MODE_PULSE = 3'h6;

  // ==========================================================================
  // source clock prescaler masks: tick when the masked bits are all ones
  localparam logic [9:0] PRESC_MASK_DIV1024 = 10'h3FF;
  localparam logic [9:0] PRESC_MASK_DIV64 = 10'h03F;
  localparam logic [9:0] PRESC_MASK_DIV4 = 10'h003;
  localparam logic [9:0] PRESC_MASK_DIV2 = 10'h001;

  // ==========================================================================
  // reset values and counter maximum
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // bit 7 down to bit 0 of the mode register
  typedef struct packed {
    logic capture_edge_mode;
    logic retrigger_stop_enable;
    logic edge_level_select;
    logic [1:0] source_clock_select;
    logic [2:0] operating_mode_field;
  } timer_mode_reg_t;

  typedef enum logic [1:0] {
    PH_WAIT,
    PH_COUNT,
    PH_GAP
  } phase_t;

  typedef struct packed {
    timer_mode_reg_t mode;
    logic run_bit;
    logic overflow_irq_enable;
    logic capture_a_done_flag;
    logic capture_b_done_flag;
    logic overflow_flag;
    logic [7:0] tmp_lo;
    logic [15:0] compare_reg_a;
    logic [15:0] compare_reg_b;
    logic [15:0] cnt;
    phase_t phase;
    logic [9:0] presc;
    logic tick;
    logic sync1;
    logic sync2;
    logic pin_prev;
    logic irq;
    logic [7:0] rdata;
  } timer_state_t;

endpackage

// *** design/ext_input_timer_counter.sv ***
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - mode 100 external trigger, edge select picks edge
// - mode and overflow enable locked while running
// - trigger starts counting; compare A match clears, interrupts
// - retrigger stop: opposite edge stops and clears counter
// - without retrigger stop, edges ignored once counting starts, also after match
// - clearing run stops and zeroes the counter
// - mode 010 counts pin edges, compare A clears
// - mode 101 counts source clock while pin level selected
// - window compare A match interrupts and clears counter
// - mode 110 pulse width, edge select start edge
// - capture mode bit: 0 double, 1 single
// - overflow interrupts only when overflow enable set
// - opposite edge captures into B, flags, interrupts
// - double: next start edge captures A, clears
// - single: opposite edge stops and clears counter
// - pulse width overflow sets overflow flag
// - status read clears all three flags
// - leading opposite edge ignored, no capture
// - counter is 16-bit upward from zero
// - compare low byte buffered, high byte commits
module ext_input_timer_counter (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire ext_timer_pkg::bus_req_t bus_req_in,
  input wire logic timer_input_pin_in,
  output logic [7:0] rdata_out,
  output logic timer_irq_out
);

  ext_timer_pkg::timer_state_t st_r;
  ext_timer_pkg::timer_state_t st_nxt;

  logic pin_rise;
  logic pin_fall;
  logic trig_edge;
  logic opp_edge;
  logic win_open;
  logic [15:0] cnt_inc;
  logic cmp_hit;

  function automatic logic bus_hit(input ext_timer_pkg::bus_req_t req, input logic [2:0] addr, input logic is_wr);
    bus_hit = (is_wr ? req.wr : req.rd) && (req.addr == addr);
  endfunction

  function automatic logic [9:0] presc_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: presc_mask = ext_timer_pkg::PRESC_MASK_DIV1024;
      2'h1: presc_mask = ext_timer_pkg::PRESC_MASK_DIV64;
      2'h2: presc_mask = ext_timer_pkg::PRESC_MASK_DIV4;
      2'h3: presc_mask = ext_timer_pkg::PRESC_MASK_DIV2;
    endcase
  endfunction

  // ==========================================================================
  // pin edge and level decode, on the synchronised copy only
  assign pin_rise = st_r.sync2 & ~st_r.pin_prev;
  assign pin_fall = ~st_r.sync2 & st_r.pin_prev;
  assign trig_edge = st_r.mode.edge_level_select ? pin_fall : pin_rise;
  assign opp_edge = st_r.mode.edge_level_select ? pin_rise : pin_fall;
  assign win_open = st_r.sync2 ^ st_r.mode.edge_level_select;
  assign cnt_inc = st_r.cnt + 16'h0001;
  assign cmp_hit = (cnt_inc == st_r.compare_reg_a);

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = timer_input_pin_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.pin_prev = st_r.sync2;
    st_nxt.presc = st_r.presc + 10'h001;
    st_nxt.tick = (st_r.presc & presc_mask(st_r.mode.source_clock_select)) ==
                  presc_mask(st_r.mode.source_clock_select);
    st_nxt.irq = 1'b0;
    st_nxt.rdata = 8'h00;

    // read side; status flags clear here and any event below sets them again
    if (bus_req_in.rd) begin
      unique case (bus_req_in.addr)
        ext_timer_pkg::ADDR_MODE: st_nxt.rdata = st_r.mode;
        ext_timer_pkg::ADDR_CTRL: begin
          st_nxt.rdata[ext_timer_pkg::CTRL_RUN_BIT] = st_r.run_bit;
          st_nxt.rdata[ext_timer_pkg::CTRL_OVE_BIT] = st_r.overflow_irq_enable;
        end
        ext_timer_pkg::ADDR_STATUS: begin
          st_nxt.rdata[ext_timer_pkg::ST_CAPA_BIT] = st_r.capture_a_done_flag;
          st_nxt.rdata[ext_timer_pkg::ST_CAPB_BIT] = st_r.capture_b_done_flag;
          st_nxt.rdata[ext_timer_pkg::ST_OVF_BIT] = st_r.overflow_flag;
          st_nxt.capture_a_done_flag = 1'b0;
          st_nxt.capture_b_done_flag = 1'b0;
          st_nxt.overflow_flag = 1'b0;
        end
        ext_timer_pkg::ADDR_CMPA_LO: st_nxt.rdata = st_r.compare_reg_a[7:0];
        ext_timer_pkg::ADDR_CMPA_HI: st_nxt.rdata = st_r.compare_reg_a[15:8];
        ext_timer_pkg::ADDR_CMPB_LO: st_nxt.rdata = st_r.compare_reg_b[7:0];
        ext_timer_pkg::ADDR_CMPB_HI: st_nxt.rdata = st_r.compare_reg_b[15:8];
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // write side
    if (bus_hit(bus_req_in, ext_timer_pkg::ADDR_MODE, 1'b1) && !st_r.run_bit) begin
      st_nxt.mode = bus_req_in.wdata;
    end
    if (bus_hit(bus_req_in, ext_timer_pkg::ADDR_CTRL, 1'b1)) begin
      st_nxt.run_bit = bus_req_in.wdata[ext_timer_pkg::CTRL_RUN_BIT];
      if (!st_r.run_bit) begin
        st_nxt.overflow_irq_enable = bus_req_in.wdata[ext_timer_pkg::CTRL_OVE_BIT];
      end
    end
    // one shared low-byte buffer keeps a 16-bit value from tearing
    if (bus_hit(bus_req_in, ext_timer_pkg::ADDR_CMPA_LO, 1'b1) ||
        bus_hit(bus_req_in, ext_timer_pkg::ADDR_CMPB_LO, 1'b1)) begin
      st_nxt.tmp_lo = bus_req_in.wdata;
    end
    if (bus_hit(bus_req_in, ext_timer_pkg::ADDR_CMPA_HI, 1'b1)) begin
      st_nxt.compare_reg_a = {bus_req_in.wdata, st_r.tmp_lo};
    end
    if (bus_hit(bus_req_in, ext_timer_pkg::ADDR_CMPB_HI, 1'b1)) begin
      st_nxt.compare_reg_b = {bus_req_in.wdata, st_r.tmp_lo};
    end

    // counter; counting starts the cycle after run is set
    if (!st_nxt.run_bit) begin
      st_nxt.cnt = ext_timer_pkg::CNT_RESET;
      st_nxt.phase = ext_timer_pkg::PH_WAIT;
    end else if (st_r.run_bit) begin
      unique case (st_r.mode.operating_mode_field)
        ext_timer_pkg::MODE_EXT_TRIG: begin
          if (st_r.phase == ext_timer_pkg::PH_WAIT) begin
            if (trig_edge) begin
              st_nxt.phase = ext_timer_pkg::PH_COUNT;
            end
          end else if (st_r.mode.retrigger_stop_enable && opp_edge) begin
            st_nxt.cnt = ext_timer_pkg::CNT_RESET;
            st_nxt.phase = ext_timer_pkg::PH_WAIT;
          end else if (st_r.tick) begin
            // further edges have no effect here while counting
            if (cmp_hit) begin
              st_nxt.cnt = ext_timer_pkg::CNT_RESET;
              st_nxt.irq = 1'b1;
            end else begin
              st_nxt.cnt = cnt_inc;
            end
          end
        end
        ext_timer_pkg::MODE_EVENT: begin
          if (trig_edge) begin
            if (cmp_hit) begin
              st_nxt.cnt = ext_timer_pkg::CNT_RESET;
              st_nxt.irq = 1'b1;
            end else begin
              st_nxt.cnt = cnt_inc;
            end
          end
        end
        ext_timer_pkg::MODE_WINDOW: begin
          if (st_r.tick && win_open) begin
            if (cmp_hit) begin
              st_nxt.cnt = ext_timer_pkg::CNT_RESET;
              st_nxt.irq = 1'b1;
            end else begin
              st_nxt.cnt = cnt_inc;
            end
          end
        end
        ext_timer_pkg::MODE_PULSE: begin
          unique case (st_r.phase)
            ext_timer_pkg::PH_WAIT: begin
              // a leading opposite edge falls through untouched
              if (trig_edge) begin
                st_nxt.phase = ext_timer_pkg::PH_COUNT;
              end
            end
            ext_timer_pkg::PH_COUNT, ext_timer_pkg::PH_GAP: begin
              if (st_r.phase == ext_timer_pkg::PH_COUNT && opp_edge) begin
                st_nxt.compare_reg_b = st_r.cnt;
                st_nxt.capture_b_done_flag = 1'b1;
                st_nxt.irq = 1'b1;
                if (st_r.mode.capture_edge_mode) begin
                  st_nxt.cnt = ext_timer_pkg::CNT_RESET;
                  st_nxt.phase = ext_timer_pkg::PH_WAIT;
                end else begin
                  st_nxt.phase = ext_timer_pkg::PH_GAP;
                end
              end else if (st_r.phase == ext_timer_pkg::PH_GAP && trig_edge) begin
                st_nxt.compare_reg_a = st_r.cnt;
                st_nxt.capture_a_done_flag = 1'b1;
                st_nxt.irq = 1'b1;
                st_nxt.cnt = ext_timer_pkg::CNT_RESET;
                st_nxt.phase = ext_timer_pkg::PH_COUNT;
              end else if (st_r.tick) begin
                st_nxt.cnt = cnt_inc;
                if (st_r.cnt == ext_timer_pkg::CNT_MAX) begin
                  st_nxt.overflow_flag = 1'b1;
                  st_nxt.irq = st_r.overflow_irq_enable;
                end
              end
            end
            default: st_nxt.phase = ext_timer_pkg::PH_WAIT;
          endcase
        end
        // free-run and pulse output modes live elsewhere; counter held
        default: st_nxt.cnt = st_r.cnt;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '{mode: ext_timer_pkg::MODE_RESET,
                compare_reg_a: ext_timer_pkg::CMP_RESET,
                compare_reg_b: ext_timer_pkg::CMP_RESET,
                cnt: ext_timer_pkg::CNT_RESET,
                phase: ext_timer_pkg::PH_WAIT,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign timer_irq_out = st_r.irq;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  logic pulse_mode;
  logic ext_mode;
  assign pulse_mode = st_r.run_bit && st_r.mode.operating_mode_field == ext_timer_pkg::MODE_PULSE;
  assign ext_mode = st_r.run_bit && st_r.mode.operating_mode_field == ext_timer_pkg::MODE_EXT_TRIG;

  // run must still be set after the edge, or the clear wins
  sequence s_opp_in_count;
    pulse_mode && st_nxt.run_bit && !st_r.mode.capture_edge_mode &&
    st_r.phase == ext_timer_pkg::PH_COUNT && opp_edge;
  endsequence

  sequence s_start_in_gap;
    pulse_mode && st_nxt.run_bit && st_r.phase == ext_timer_pkg::PH_GAP && trig_edge;
  endsequence

  a_mode_write_lock: assert property (
    st_r.run_bit && bus_hit(bus_req_in, ext_timer_pkg::ADDR_MODE, 1'b1) |=> $stable(st_r.mode))
    else $error("mode register changed while running");

  a_stop_clears_count: assert property (
    !st_r.run_bit |-> st_r.cnt == ext_timer_pkg::CNT_RESET && st_r.phase == ext_timer_pkg::PH_WAIT)
    else $error("counter not cleared while stopped");

  a_ext_match_clear: assert property (
    ext_mode && st_r.phase == ext_timer_pkg::PH_COUNT && st_r.tick && cmp_hit &&
    !(st_r.mode.retrigger_stop_enable && opp_edge) && st_nxt.run_bit
    |=> st_r.irq && st_r.cnt == ext_timer_pkg::CNT_RESET)
    else $error("external trigger match did not clear and interrupt");

  a_retrig_stop: assert property (
    ext_mode && st_nxt.run_bit && st_r.phase == ext_timer_pkg::PH_COUNT &&
    st_r.mode.retrigger_stop_enable && opp_edge
    |=> st_r.cnt == ext_timer_pkg::CNT_RESET && st_r.phase == ext_timer_pkg::PH_WAIT)
    else $error("opposite edge did not stop the counter");

  a_event_count: assert property (
    st_r.run_bit && st_nxt.run_bit && st_r.mode.operating_mode_field == ext_timer_pkg::MODE_EVENT &&
    trig_edge && !cmp_hit |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
    else $error("event edge not counted");

  a_window_gate: assert property (
    st_r.run_bit && st_nxt.run_bit && st_r.mode.operating_mode_field == ext_timer_pkg::MODE_WINDOW &&
    !win_open |=> $stable(st_r.cnt))
    else $error("counter moved with window closed");

  a_capture_b: assert property (
    pulse_mode && st_nxt.run_bit && st_r.phase == ext_timer_pkg::PH_COUNT && opp_edge
    |=> st_r.compare_reg_b == $past(st_r.cnt) && st_r.capture_b_done_flag && st_r.irq)
    else $error("opposite edge capture into B missing");

  a_double_keeps_count: assert property (
    s_opp_in_count |=> st_r.phase == ext_timer_pkg::PH_GAP && st_r.cnt == $past(st_r.cnt))
    else $error("double-edge capture stopped the counter");

  a_double_capture_a: assert property (
    s_start_in_gap
    |=> st_r.capture_a_done_flag && st_r.irq && st_r.cnt == ext_timer_pkg::CNT_RESET &&
    st_r.compare_reg_a == $past(st_r.cnt))
    else $error("double-edge capture into A missing");

  a_single_stop: assert property (
    pulse_mode && st_nxt.run_bit && st_r.mode.capture_edge_mode &&
    st_r.phase == ext_timer_pkg::PH_COUNT && opp_edge
    |=> st_r.cnt == ext_timer_pkg::CNT_RESET && st_r.phase == ext_timer_pkg::PH_WAIT)
    else $error("single-edge capture did not stop counter");

  a_lead_opp_ignored: assert property (
    pulse_mode && st_r.phase == ext_timer_pkg::PH_WAIT && opp_edge
    |=> !st_r.irq && st_r.phase == ext_timer_pkg::PH_WAIT)
    else $error("leading opposite edge raised interrupt");

  // a wrap takes 64k ticks, beyond any short test; watched here only
  a_ovf_irq_gate: assert property (
    pulse_mode && st_nxt.run_bit && st_r.phase != ext_timer_pkg::PH_WAIT && st_r.tick &&
    !trig_edge && !opp_edge && st_r.cnt == ext_timer_pkg::CNT_MAX
    |=> st_r.overflow_flag && st_r.irq == $past(st_r.overflow_irq_enable) &&
    st_r.cnt == ext_timer_pkg::CNT_RESET)
    else $error("overflow flag or interrupt gating broken");

  a_status_clear: assert property (
    !st_r.run_bit && bus_hit(bus_req_in, ext_timer_pkg::ADDR_STATUS, 1'b0)
    |=> !st_r.capture_a_done_flag && !st_r.capture_b_done_flag && !st_r.overflow_flag)
    else $error("status read did not clear flags");

  a_cmp_commit: assert property (
    !st_r.run_bit && bus_hit(bus_req_in, ext_timer_pkg::ADDR_CMPA_HI, 1'b1)
    |=> st_r.compare_reg_a == {$past(bus_req_in.wdata), $past(st_r.tmp_lo)})
    else $error("compare high write did not commit buffered low byte");

  a_cmpb_commit: assert property (
    !st_r.run_bit && bus_hit(bus_req_in, ext_timer_pkg::ADDR_CMPB_HI, 1'b1)
    |=> st_r.compare_reg_b == {$past(bus_req_in.wdata), $past(st_r.tmp_lo)})
    else $error("compare B high write did not commit buffered low byte");

  a_trig_start: assert property (
    ext_mode && st_nxt.run_bit && st_r.phase == ext_timer_pkg::PH_WAIT && trig_edge
    |=> st_r.phase == ext_timer_pkg::PH_COUNT && st_r.cnt == ext_timer_pkg::CNT_RESET)
    else $error("trigger edge did not start the counter");

  a_no_retrig_hold: assert property (
    ext_mode && st_nxt.run_bit && st_r.phase == ext_timer_pkg::PH_COUNT && !st_r.mode.retrigger_stop_enable
    |=> st_r.phase == ext_timer_pkg::PH_COUNT)
    else $error("edge disturbed counting without retrigger stop");

  a_event_match: assert property (
    st_r.run_bit && st_nxt.run_bit && st_r.mode.operating_mode_field == ext_timer_pkg::MODE_EVENT &&
    trig_edge && cmp_hit |=> st_r.irq && st_r.cnt == ext_timer_pkg::CNT_RESET)
    else $error("event match did not clear and interrupt");

  a_window_match: assert property (
    st_r.run_bit && st_nxt.run_bit && st_r.mode.operating_mode_field == ext_timer_pkg::MODE_WINDOW &&
    st_r.tick && win_open && cmp_hit |=> st_r.irq && st_r.cnt == ext_timer_pkg::CNT_RESET)
    else $error("window match did not clear and interrupt");

  a_pulse_start: assert property (
    pulse_mode && st_nxt.run_bit && st_r.phase == ext_timer_pkg::PH_WAIT && trig_edge
    |=> st_r.phase == ext_timer_pkg::PH_COUNT && st_r.cnt == ext_timer_pkg::CNT_RESET && !st_r.irq)
    else $error("start edge did not begin measurement");

  a_ove_write_lock: assert property (
    st_r.run_bit && bus_hit(bus_req_in, ext_timer_pkg::ADDR_CTRL, 1'b1) |=> $stable(st_r.overflow_irq_enable))
    else $error("overflow enable changed while running");

  a_run_clear_stops: assert property (
    bus_hit(bus_req_in, ext_timer_pkg::ADDR_CTRL, 1'b1) && !bus_req_in.wdata[ext_timer_pkg::CTRL_RUN_BIT]
    |=> !st_r.run_bit && st_r.cnt == ext_timer_pkg::CNT_RESET && st_r.phase == ext_timer_pkg::PH_WAIT)
    else $error("clearing run did not stop the counter");

  a_status_data: assert property (
    bus_hit(bus_req_in, ext_timer_pkg::ADDR_STATUS, 1'b0)
    |=> st_r.rdata[ext_timer_pkg::ST_CAPA_BIT] == $past(st_r.capture_a_done_flag) &&
    st_r.rdata[ext_timer_pkg::ST_CAPB_BIT] == $past(st_r.capture_b_done_flag) &&
    st_r.rdata[ext_timer_pkg::ST_OVF_BIT] == $past(st_r.overflow_flag))
    else $error("status read data wrong");

endmodule

`default_nettype wire

// *** bench/pin_source.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// far-side pulse source: drives the timer pin only
module pin_source (
  input wire logic mclk_in,
  output var logic pin_out
);
  initial begin
    pin_out = 1'b0;
  end

  // a level never shorter than two clocks, so event counting stays legal
  task automatic hold(input logic level, input int cycles);
    int n;
    n = (cycles < 2) ? 2 : cycles;
    @(posedge mclk_in);
    pin_out <= level;
    repeat (n - 1) @(posedge mclk_in);
  endtask
endmodule

`default_nettype wire

// *** bench/tb_ext_input_timer_counter.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_ext_input_timer_counter;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  ext_timer_pkg::bus_req_t bus_req = '0;
  wire logic pin;
  logic [7:0] rdata;
  logic irq;
  int miscompares = 0;
  int compares = 0;
  int irq_count = 0;
  int irq_base = 0;
  int cycles = 0;

  always #25 mclk_in = ~mclk_in;

  ext_input_timer_counter ext_input_timer_counter_inst (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .bus_req_in(bus_req),
    .timer_input_pin_in(pin),
    .rdata_out(rdata),
    .timer_irq_out(irq)
  );

  pin_source pin_source_inst (
    .mclk_in(mclk_in),
    .pin_out(pin)
  );

  // ==========================================================================
  // interrupt pulse counter and hang guard
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) begin
      irq_count <= irq_count + 1;
    end
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================================
  // access tasks
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // tol covers the free-running prescaler phase
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp, input int tol);
    logic ok;
    compares++;
    ok = (tol == 0) ? (seen === exp) : (!$isunknown(seen) && int'(seen) + tol >= int'(exp)
      && int'(seen) <= int'(exp) + tol);
    if (!ok) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_req <= '0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, {8'h00, d}, {8'h00, exp}, 0);
  endtask

  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 3'h1, hi);
    v = {hi, lo};
  endtask

  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 3'h1, v[15:8]);
  endtask

  task automatic start(input logic [7:0] mode);
    wr(ext_timer_pkg::ADDR_CTRL, 8'h00);
    wr(ext_timer_pkg::ADDR_MODE, mode);
    wr(ext_timer_pkg::ADDR_CTRL, 8'h01);
    irq_base = irq_count;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      pin_source_inst.hold(1'b1, 3);
      pin_source_inst.hold(1'b0, 3);
    end
  endtask

  task automatic irqchk(input logic [15:0] n);
    repeat (6) @(posedge mclk_in);
    check("irq_count", 16'(irq_count - irq_base), n, 0);
  endtask

  // ==========================================================================
  // tests
  initial begin
    logic [15:0] v;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rchk("mode", ext_timer_pkg::ADDR_MODE, 8'h00);
    rchk("ctrl", ext_timer_pkg::ADDR_CTRL, 8'h00);
    rchk("status", ext_timer_pkg::ADDR_STATUS, 8'h00);
    rd16(ext_timer_pkg::ADDR_CMPB_LO, v);
    check("cmp_b", v, 16'hFFFF, 0);
    rchk("unmapped", 3'h7, 8'h00);
    wr(ext_timer_pkg::ADDR_CMPA_LO, 8'h34);
    wr(3'h7, 8'h55);
    rd16(ext_timer_pkg::ADDR_CMPA_LO, v);
    check("cmp_a_pending", v, 16'hFFFF, 0);
    wr(ext_timer_pkg::ADDR_CMPA_HI, 8'h12);
    rd16(ext_timer_pkg::ADDR_CMPA_LO, v);
    check("cmp_a", v, 16'h1234, 0);
    wr16(ext_timer_pkg::ADDR_CMPB_LO, 16'h5678);
    rd16(ext_timer_pkg::ADDR_CMPB_LO, v);
    check("cmp_b_write", v, 16'h5678, 0);
    $display("test registers done");

    // event count, period of three rising edges
    wr16(ext_timer_pkg::ADDR_CMPA_LO, 16'h0003);
    start(8'h02);
    wr(ext_timer_pkg::ADDR_MODE, 8'h00);
    wr(ext_timer_pkg::ADDR_CTRL, 8'h03);
    rchk("mode_locked", ext_timer_pkg::ADDR_MODE, 8'h02);
    rchk("ove_locked", ext_timer_pkg::ADDR_CTRL, 8'h01);
    pulses(2);
    irqchk(16'h0000);
    pulses(1);
    irqchk(16'h0001);
    pulses(2);
    wr(ext_timer_pkg::ADDR_CTRL, 8'h00);
    wr(ext_timer_pkg::ADDR_CTRL, 8'h01);
    pulses(2);
    irqchk(16'h0001);
    pulses(1);
    irqchk(16'h0002);
    $display("test event done");

    // external trigger, ten ticks at clock/2
    wr(ext_timer_pkg::ADDR_CTRL, 8'h00);
    wr16(ext_timer_pkg::ADDR_CMPA_LO, 16'h000A);
    start(8'h5C);
    pin_source_inst.hold(1'b1, 14);
    pin_source_inst.hold(1'b0, 4);
    pin_source_inst.hold(1'b1, 14);
    pin_source_inst.hold(1'b0, 4);
    irqchk(16'h0000);
    pin_source_inst.hold(1'b1, 30);
    pin_source_inst.hold(1'b0, 4);
    irqchk(16'h0001);
    start(8'h1C);
    pin_source_inst.hold(1'b1, 8);
    pin_source_inst.hold(1'b0, 24);
    irqchk(16'h0001);
    $display("test trigger done");

    // window counting while the pin is low
    wr(ext_timer_pkg::ADDR_CTRL, 8'h00);
    pin_source_inst.hold(1'b1, 4);
    start(8'h3D);
    pin_source_inst.hold(1'b1, 60);
    pin_source_inst.hold(1'b0, 30);
    pin_source_inst.hold(1'b1, 40);
    irqchk(16'h0001);
    $display("test window done");

    // single-edge pulse width; pin already high so first edge is opposite
    start(8'h9E);
    rchk("status_clear", ext_timer_pkg::ADDR_STATUS, 8'h00);
    pin_source_inst.hold(1'b0, 10);
    irqchk(16'h0000);
    rchk("status_lead", ext_timer_pkg::ADDR_STATUS, 8'h00);
    pin_source_inst.hold(1'b1, 40);
    pin_source_inst.hold(1'b0, 10);
    irqchk(16'h0001);
    rchk("status_capb", ext_timer_pkg::ADDR_STATUS, 8'h02);
    rchk("status_read", ext_timer_pkg::ADDR_STATUS, 8'h00);
    rd16(ext_timer_pkg::ADDR_CMPB_LO, v);
    check("cap_b", v, 16'h0014, 1);
    pin_source_inst.hold(1'b1, 20);
    pin_source_inst.hold(1'b0, 10);
    rd16(ext_timer_pkg::ADDR_CMPB_LO, v);
    check("cap_b_single", v, 16'h000A, 1);
    $display("test single capture done");

    // double-edge pulse width
    start(8'h1E);
    pin_source_inst.hold(1'b1, 40);
    pin_source_inst.hold(1'b0, 20);
    pin_source_inst.hold(1'b1, 4);
    irqchk(16'h0002);
    rchk("status_both", ext_timer_pkg::ADDR_STATUS, 8'h03);
    rd16(ext_timer_pkg::ADDR_CMPB_LO, v);
    check("cap_b_double", v, 16'h0014, 1);
    rd16(ext_timer_pkg::ADDR_CMPA_LO, v);
    // a tick that meets the opposite edge is lost, so 28 to 30
    check("cap_a_double", v, 16'h001D, 1);
    $display("test double capture done");

    // falling-edge events, then a window at clock/4 while the pin is high
    wr16(ext_timer_pkg::ADDR_CMPA_LO, 16'h0002);
    start(8'h22);
    pulses(1);
    irqchk(16'h0000);
    pulses(1);
    irqchk(16'h0001);
    start(8'h15);
    pin_source_inst.hold(1'b1, 12);
    pin_source_inst.hold(1'b0, 8);
    irqchk(16'h0001);
    $display("test falling edge and divider done");
    complete_run();
  end
endmodule

`default_nettype wire
